// *** hw/bml_loader.sv ***
// Boot-mode strap capture, serial image load and first-boot formatting
module bml_loader #(
  parameter int BRK_WAIT = bml_pkg::BREAK_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Boot pins
  input  wire logic        reset_n_pin,
  input  wire logic [2:0]  boot_strap_pins,
  // Serial link, transmit and receive only
  input  wire logic        uart_rxd,
  output logic             uart_txd,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Flash store side
  input  wire logic        image_present,
  input  wire logic        format_done,
  output logic             format_start,
  output logic             image_protect,
  output logic             flash_direct_en,
  // Boot outcome
  output logic             jtag_4wire,
  output logic             load_active,
  output logic             run_enable
);
  if (BRK_WAIT < 2 || BRK_WAIT > 1_000_000)
    $error("bml_loader: break wait out of range");

  ////////////////////////////////////////////////////////////////////
  // Strap decode
  function automatic bml_pkg::bml_mode_t strap_mode(input logic [2:0] s);
    if (s == bml_pkg::STRAP_LOAD)
      return bml_pkg::MODE_LOAD;
    else if (s == bml_pkg::STRAP_BRKSEL)
      return bml_pkg::MODE_BRKSEL;
    else
      return bml_pkg::MODE_FUNC;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       rstp_s1, rstp_s2, rstp_d;
  logic [2:0] strap_s1, strap_s2;
  logic       pin_release;

  always_ff @(posedge clk)
  begin
    rstp_s1  <= reset_n_pin;
    rstp_s2  <= rstp_s1;
    rstp_d   <= rstp_s2;
    strap_s1 <= boot_strap_pins;
    strap_s2 <= strap_s1;
    if (reset)
    begin
      rstp_s1  <= 1'b0;
      rstp_s2  <= 1'b0;
      rstp_d   <= 1'b0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end
  end

  assign pin_release = rstp_s2 && !rstp_d;

  ////////////////////////////////////////////////////////////////////
  // Serial engine; no handshake lines exist on this link
  logic       rx_valid, rx_break, tx_busy, tx_start;
  logic [7:0] rx_data, tx_data;

  bml_uart #(
    .BIT_CYC (bml_pkg::BIT_CYCLES),
    .BRK_CYC (bml_pkg::BREAK_CYCLES)
  ) u_uart (
    .clk      (clk),
    .reset    (reset),
    .rxd      (uart_rxd),
    .txd      (uart_txd),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_break (rx_break),
    .tx_start (tx_start),
    .tx_data  (tx_data),
    .tx_busy  (tx_busy)
  );

  ////////////////////////////////////////////////////////////////////
  // Boot sequencer
  bml_pkg::bml_mode_t  mode, next_mode;
  bml_pkg::bml_state_t state, next_state;
  logic [19:0]         wait_cnt, next_wait_cnt;
  logic                formatted, next_formatted;
  logic                next_format_start;
  logic                break_seen, next_break_seen;

  // Run path: a present image is converted before first run
  function automatic bml_pkg::bml_state_t run_path(input logic img,
                                                   input logic fmt);
    return (img && !fmt) ? bml_pkg::ST_FORMAT : bml_pkg::ST_RUN;
  endfunction

  always_comb
  begin
    next_mode         = mode;
    next_state        = state;
    next_wait_cnt     = wait_cnt;
    next_formatted    = formatted;
    next_format_start = 1'b0;
    next_break_seen   = break_seen;
    unique case (state)
      bml_pkg::ST_HOLD:
        if (pin_release)
        begin
          next_mode = strap_mode(strap_s2);
          unique case (strap_mode(strap_s2))
            bml_pkg::MODE_LOAD:
              next_state = bml_pkg::ST_LOAD;
            bml_pkg::MODE_BRKSEL:
            begin
              next_state    = bml_pkg::ST_CHECK;
              next_wait_cnt = 20'(BRK_WAIT - 1);
            end
            bml_pkg::MODE_FUNC:
            begin
              next_state        = run_path(image_present, formatted);
              next_format_start = image_present && !formatted;
            end
          endcase
        end
      bml_pkg::ST_CHECK:
        if (rx_break)
        begin
          next_state      = bml_pkg::ST_LOAD;
          next_break_seen = 1'b1;
        end
        else if (wait_cnt == 20'h00000)
        begin
          next_state        = run_path(image_present, formatted);
          next_format_start = image_present && !formatted;
        end
        else
          next_wait_cnt = wait_cnt - 20'h00001;
      // Left only by a pin reset; no timeout
      bml_pkg::ST_LOAD:
        next_state = bml_pkg::ST_LOAD;
      // Conversion waits on the store only; serial input is ignored
      bml_pkg::ST_FORMAT:
        if (format_done)
        begin
          next_state     = bml_pkg::ST_RUN;
          next_formatted = 1'b1;
        end
      bml_pkg::ST_RUN:
        next_state = bml_pkg::ST_RUN;
      default:
        next_state = bml_pkg::ST_HOLD;
    endcase
    if (!rstp_s2)
    begin
      next_state      = bml_pkg::ST_HOLD;
      next_break_seen = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode         <= bml_pkg::MODE_FUNC;
      state        <= bml_pkg::ST_HOLD;
      wait_cnt     <= 20'h00000;
      formatted    <= 1'b0;
      format_start <= 1'b0;
      break_seen   <= 1'b0;
    end
    else
    begin
      mode         <= next_mode;
      state        <= next_state;
      wait_cnt     <= next_wait_cnt;
      formatted    <= next_formatted;
      format_start <= next_format_start;
      break_seen   <= next_break_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin outputs
  logic next_jtag, next_load, next_run, next_prot, next_direct;
  logic enc_image;

  always_comb
  begin
    // Both serial-load modes keep the full 4-wire debug port
    next_jtag = (next_state != bml_pkg::ST_HOLD) &&
                (next_mode != bml_pkg::MODE_FUNC);
    next_load = (next_state == bml_pkg::ST_LOAD);
    next_run  = (next_state == bml_pkg::ST_RUN);
    // Image stays write-protected beside the file system
    next_prot = next_formatted;
    // Direct flash path only while held in reset and never for encrypted
    next_direct = (next_state == bml_pkg::ST_HOLD) && !enc_image;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      jtag_4wire      <= 1'b0;
      load_active     <= 1'b0;
      run_enable      <= 1'b0;
      image_protect   <= 1'b0;
      flash_direct_en <= 1'b0;
    end
    else
    begin
      jtag_4wire      <= next_jtag;
      load_active     <= next_load;
      run_enable      <= next_run;
      image_protect   <= next_prot;
      flash_direct_en <= next_direct;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file
  logic        rx_avail, next_rx_avail;
  logic        rx_overrun, next_rx_overrun;
  logic [7:0]  rx_hold, next_rx_hold;
  logic        next_enc;
  logic [31:0] fs_size, next_fs_size;
  logic [31:0] next_rdata;
  logic        rx_take, rd_rx;

  assign rx_take  = rx_valid && (state == bml_pkg::ST_LOAD ||
                                 state == bml_pkg::ST_RUN);
  assign rd_rx    = rd && (addr == bml_pkg::OFS_RXDATA);
  assign tx_start = wr && (addr == bml_pkg::OFS_TXDATA) && !tx_busy;
  assign tx_data  = wdata[7:0];

  always_comb
  begin
    next_enc        = enc_image;
    next_fs_size    = fs_size;
    next_rx_hold    = rx_take ? rx_data : rx_hold;
    // A byte arriving with the clearing read still sets the flag
    next_rx_avail   = rx_take || (rx_avail && !rd_rx);
    next_rx_overrun = (rx_take && rx_avail && !rd_rx) ||
                      (rx_overrun && !rd_rx);
    if (wr && addr == bml_pkg::OFS_CTRL)
      next_enc = wdata[bml_pkg::CTRL_ENC];
    if (wr && addr == bml_pkg::OFS_FSSIZE && !formatted)
      next_fs_size = wdata;
    next_rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        bml_pkg::OFS_CTRL:
          next_rdata[bml_pkg::CTRL_ENC] = enc_image;
        bml_pkg::OFS_STATUS:
        begin
          next_rdata[bml_pkg::ST_RX_AVAIL]   = rx_avail;
          next_rdata[bml_pkg::ST_RX_OVERRUN] = rx_overrun;
          next_rdata[bml_pkg::ST_TX_BUSY]    = tx_busy;
          next_rdata[bml_pkg::ST_BREAK]      = break_seen;
          next_rdata[bml_pkg::ST_FORMATTED]  = formatted;
          next_rdata[bml_pkg::ST_MODE_LSB +: 2] = mode;
          // Straps still in a programming setting while running
          next_rdata[bml_pkg::ST_STRAP_PROG] =
            strap_mode(strap_s2) != bml_pkg::MODE_FUNC;
          next_rdata[bml_pkg::ST_STATE_LSB +: 3] = state;
        end
        bml_pkg::OFS_RXDATA:
          next_rdata[7:0] = rx_hold;
        bml_pkg::OFS_FSSIZE:
          next_rdata = fs_size;
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      enc_image  <= 1'b0;
      fs_size    <= bml_pkg::FSSIZE_RST;
      rx_hold    <= 8'h00;
      rx_avail   <= 1'b0;
      rx_overrun <= 1'b0;
      rdata      <= 32'h0000_0000;
    end
    else
    begin
      enc_image  <= next_enc;
      fs_size    <= next_fs_size;
      rx_hold    <= next_rx_hold;
      rx_avail   <= next_rx_avail;
      rx_overrun <= next_rx_overrun;
      rdata      <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  AST_STRAP_LOAD: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_HOLD && pin_release && rstp_s2 &&
    strap_s2 == bml_pkg::STRAP_LOAD |-> ##1
    state == bml_pkg::ST_LOAD ##1 load_active)
    else $error("load-only strap did not enter load");

  AST_STRAP_BRK: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_HOLD && pin_release && rstp_s2 &&
    strap_s2 == bml_pkg::STRAP_BRKSEL |-> ##1
    state == bml_pkg::ST_CHECK && mode == bml_pkg::MODE_BRKSEL)
    else $error("break-select strap did not enter check");

  AST_LOAD_STAYS: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_LOAD && rstp_s2 |=> state == bml_pkg::ST_LOAD &&
    !run_enable)
    else $error("load mode fell through");

  AST_JTAG_LOAD: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_LOAD && mode == bml_pkg::MODE_LOAD |-> jtag_4wire)
    else $error("debug port not 4-wire in load mode");

  AST_JTAG_BRK: assert property (@(posedge clk) disable iff (reset)
    state != bml_pkg::ST_HOLD && mode == bml_pkg::MODE_BRKSEL |-> jtag_4wire)
    else $error("debug signals not kept in break-select mode");

  AST_BREAK_LOAD: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_CHECK && rx_break && rstp_s2 |=>
    state == bml_pkg::ST_LOAD ##1 load_active && !run_enable)
    else $error("break did not select load");

  AST_FORMAT_ALONE: assert property (@(posedge clk) disable iff (reset)
    state == bml_pkg::ST_FORMAT && !format_done && rstp_s2 |=>
    state == bml_pkg::ST_FORMAT && !run_enable)
    else $error("conversion left without its done");

  AST_IMG_KEPT: assert property (@(posedge clk) disable iff (reset)
    formatted |=> image_protect && $stable(formatted))
    else $error("image not protected after formatting");

  AST_FS_LOCK: assert property (@(posedge clk) disable iff (reset)
    formatted |=> $stable(fs_size))
    else $error("flash size changed after formatting");

  AST_ENC_DIRECT: assert property (@(posedge clk) disable iff (reset)
    enc_image |=> !flash_direct_en)
    else $error("direct flash path open for encrypted image");

  AST_MODE_HOLD: assert property (@(posedge clk) disable iff (reset)
    state != bml_pkg::ST_HOLD |=> $stable(mode))
    else $error("boot mode changed outside reset");
endmodule // bml_loader

// *** hw/bml_uart.sv ***
// Fixed-rate 8N1 serial receiver, transmitter and break detector
module bml_uart #(
  parameter int BIT_CYC = bml_pkg::BIT_CYCLES,
  parameter int BRK_CYC = bml_pkg::BREAK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Serial lines
  input  wire logic       rxd,
  output logic            txd,
  // Receive side
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_break,
  // Transmit side
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  output logic            tx_busy
);
  // Counters are 16 bits wide, so longer bit or break times cannot be served
  if (BIT_CYC < 4 || BRK_CYC <= BIT_CYC * 10 || BRK_CYC > 65_535)
    $error("bml_uart: bit or break length out of range");

  logic        rx_s1, rx_s2;
  logic        rx_act, next_rx_act;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [3:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_sh, next_rx_sh;
  logic        next_rx_valid;
  logic [7:0]  next_rx_data;
  logic [15:0] low_cnt, next_low_cnt;
  logic        next_rx_break;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0]  tx_bit, next_tx_bit;
  logic [9:0]  tx_sh, next_tx_sh;
  logic        next_txd, next_tx_busy;

  // Receiver: sample mid-bit, start, 8 data LSB first, 1 stop; no parity
  always_comb
  begin
    next_rx_act   = rx_act;
    next_rx_cnt   = rx_cnt;
    next_rx_bit   = rx_bit;
    next_rx_sh    = rx_sh;
    next_rx_valid = 1'b0;
    next_rx_data  = rx_data;
    if (!rx_act)
    begin
      if (!rx_s2)
      begin
        next_rx_act = 1'b1;
        next_rx_cnt = 16'(BIT_CYC / 2);
        next_rx_bit = 4'h0;
      end
    end
    else if (rx_cnt != 16'h0000)
      next_rx_cnt = rx_cnt - 16'h0001;
    else
    begin
      next_rx_cnt = 16'(BIT_CYC - 1);
      next_rx_bit = rx_bit + 4'h1;
      if (rx_bit == 4'h0)
        next_rx_act = !rx_s2;
      else if (rx_bit <= 4'(bml_pkg::FRAME_DATA))
        next_rx_sh = {rx_s2, rx_sh[7:1]};
      else
      begin
        next_rx_act   = 1'b0;
        next_rx_valid = rx_s2;
        next_rx_data  = rx_s2 ? rx_sh : rx_data;
      end
    end
  end

  // Break: line held low longer than a whole frame
  always_comb
  begin
    next_low_cnt  = rx_s2 ? 16'h0000 : low_cnt;
    next_rx_break = 1'b0;
    if (!rx_s2 && low_cnt != 16'(BRK_CYC))
      next_low_cnt = low_cnt + 16'h0001;
    if (!rx_s2 && low_cnt == 16'(BRK_CYC - 1))
      next_rx_break = 1'b1;
  end

  // Transmitter; a start while busy is dropped
  always_comb
  begin
    next_tx_cnt  = tx_cnt;
    next_tx_bit  = tx_bit;
    next_tx_sh   = tx_sh;
    next_txd     = txd;
    next_tx_busy = tx_busy;
    if (!tx_busy)
    begin
      if (tx_start)
      begin
        next_tx_sh   = {1'b1, tx_data, 1'b0};
        next_tx_busy = 1'b1;
        next_tx_cnt  = 16'(BIT_CYC - 1);
        next_tx_bit  = 4'h0;
        next_txd     = 1'b0;
      end
    end
    else if (tx_cnt != 16'h0000)
      next_tx_cnt = tx_cnt - 16'h0001;
    else if (tx_bit == 4'h9)
      next_tx_busy = 1'b0;
    else
    begin
      next_tx_cnt = 16'(BIT_CYC - 1);
      next_tx_bit = tx_bit + 4'h1;
      next_txd    = tx_sh[tx_bit + 4'h1];
    end
  end

  always_ff @(posedge clk)
  begin
    rx_s1 <= rxd;
    rx_s2 <= rx_s1;
    if (reset)
    begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_act   <= 1'b0;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_sh    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      low_cnt  <= 16'h0000;
      rx_break <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_sh    <= 10'h3FF;
      txd      <= 1'b1;
      tx_busy  <= 1'b0;
    end
    else
    begin
      rx_act   <= next_rx_act;
      rx_cnt   <= next_rx_cnt;
      rx_bit   <= next_rx_bit;
      rx_sh    <= next_rx_sh;
      rx_valid <= next_rx_valid;
      rx_data  <= next_rx_data;
      low_cnt  <= next_low_cnt;
      rx_break <= next_rx_break;
      tx_cnt   <= next_tx_cnt;
      tx_bit   <= next_tx_bit;
      tx_sh    <= next_tx_sh;
      txd      <= next_txd;
      tx_busy  <= next_tx_busy;
    end
  end
endmodule // bml_uart

// *** inc/bml_pkg.sv ***
// Shared constants and types for the boot-mode serial loader
package bml_pkg;
  // Clock and serial link
  localparam int CLK_HZ        = 100_000_000;
  localparam int BAUD_BPS      = 921_600;
  localparam int BIT_CYCLES    = CLK_HZ / BAUD_BPS;
  localparam int BREAK_BITS    = 11;
  localparam int BREAK_CYCLES  = BIT_CYCLES * BREAK_BITS;
  localparam int FRAME_DATA    = 8;
  // Window in which a break may arrive in the break-select mode
  localparam int BREAK_WAIT_US = 1000;
  localparam int BREAK_WAIT_CYC = BREAK_WAIT_US * (CLK_HZ / 1_000_000);

  // Strap encodings, bit 2 down to bit 0
  localparam logic [2:0] STRAP_LOAD   = 3'h4;
  localparam logic [2:0] STRAP_BRKSEL = 3'h2;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_FSSIZE = 8'h10;

  // Field positions
  localparam int CTRL_ENC      = 0;
  localparam int ST_RX_AVAIL   = 0;
  localparam int ST_RX_OVERRUN = 1;
  localparam int ST_TX_BUSY    = 2;
  localparam int ST_BREAK      = 3;
  localparam int ST_FORMATTED  = 4;
  localparam int ST_MODE_LSB   = 5;
  localparam int ST_STRAP_PROG = 7;
  localparam int ST_STATE_LSB  = 8;

  // Reset values
  localparam logic [31:0] FSSIZE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_FUNC,
    MODE_LOAD,
    MODE_BRKSEL
  } bml_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_CHECK,
    ST_LOAD,
    ST_FORMAT,
    ST_RUN
  } bml_state_t;
endpackage

// *** verification/bml_loader_test.sv ***
// Self-checking bench for the boot-mode serial loader
module bml_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BW = 2000;
  logic        clk;
  logic        reset;
  logic        reset_n_pin;
  logic [2:0]  boot_strap_pins;
  logic        uart_rxd;
  logic        uart_txd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        image_present;
  logic        format_done;
  logic        format_start;
  logic        image_protect;
  logic        flash_direct_en;
  logic        jtag_4wire;
  logic        load_active;
  logic        run_enable;
  int          err_total;
  int          samples_checked;
  int          fs_cnt;

  bml_loader #(.BRK_WAIT(BW)) i_dut (
    .clk(clk), .reset(reset), .reset_n_pin(reset_n_pin),
    .boot_strap_pins(boot_strap_pins), .uart_rxd(uart_rxd),
    .uart_txd(uart_txd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .image_present(image_present),
    .format_done(format_done), .format_start(format_start),
    .image_protect(image_protect), .flash_direct_en(flash_direct_en),
    .jtag_4wire(jtag_4wire), .load_active(load_active),
    .run_enable(run_enable)
  );
  bml_programmer i_prog (
    .clk(clk), .txd(uart_txd), .rxd(uart_rxd),
    .reset_n_pin(reset_n_pin), .boot_strap_pins(boot_strap_pins)
  );

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (format_start === 1'h1)
      fs_cnt++;

  function automatic logic [1:0] exp_mode(input logic [2:0] s);
    return (s == 3'h4) ? 2'h1 : (s == 3'h2) ? 2'h2 : 2'h0;
  endfunction

  function automatic logic probe(input int k);
    case (k)
      0: return load_active;
      1: return run_enable;
      default: return format_start;
    endcase
  endfunction

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_hi(input int k, input int lim);
    int n;
    n = 0;
    while (probe(k) !== 1'h1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        final_report();
      end
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [31:0] x;
    logic [7:0]  b;
    logic [7:0]  b2;
    logic        ok;
    logic [2:0]  s;
    reset = 1'h1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'h0;
    rd = 1'h0;
    image_present = 1'h0;
    format_done = 1'h0;
    void'($urandom(75));
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    chk(uart_txd, 1'h1);
    chk({run_enable, load_active, format_start}, 3'h0);
    chk(flash_direct_en, 1'h1);
    rd_reg(bml_pkg::OFS_FSSIZE, d);
    chk(d, bml_pkg::FSSIZE_RST);
    wr_reg(bml_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk(flash_direct_en, 1'h0);
    wr_reg(8'h20, $urandom);
    rd_reg(8'h20, d);
    chk(d, 32'h0000_0000);
    wr_reg(bml_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test registers done");

    i_prog.boot(3'h4);
    wait_hi(0, 100);
    repeat (BW + 1300) @(posedge clk);
    #1;
    chk({run_enable, load_active, jtag_4wire}, 3'h3);
    i_prog.set_strap(3'h0);
    repeat (10) @(posedge clk);
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk(d[10:5], {3'h2, 1'h0, exp_mode(3'h4)});
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      i_prog.send_byte(b);
      repeat (20) @(posedge clk);
      rd_reg(bml_pkg::OFS_RXDATA, d);
      chk(d, {24'h0, b});
    end
    b = 8'hFF;
    b2 = 8'h00;
    i_prog.send_byte(b);
    i_prog.send_byte(b2);
    repeat (20) @(posedge clk);
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk(d[2:0], 3'h3);
    rd_reg(bml_pkg::OFS_RXDATA, d);
    chk(d, {24'h0, b2});
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk(d[2:0], 3'h0);
    b = 8'($urandom);
    wr_reg(bml_pkg::OFS_TXDATA, {24'h0, b});
    // Busy shows while the frame is out; the next write is dropped
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk(d[2], 1'h1);
    wr_reg(bml_pkg::OFS_TXDATA, 32'h0000_00A5);
    i_prog.recv_byte(b2, ok);
    chk({b2, ok}, {b, 1'h1});
    i_prog.recv_byte(b2, ok);
    chk(ok, 1'h0);
    $display("test load-only done");

    i_prog.boot(3'h2);
    #1;
    chk(load_active, 1'h0);
    i_prog.send_break();
    wait_hi(0, BW);
    chk(jtag_4wire, 1'h1);
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk(d[6:3], {exp_mode(3'h2), 2'h1});
    i_prog.boot(3'h2);
    repeat (BW / 2) @(posedge clk);
    #1;
    chk({run_enable, load_active}, 2'h0);
    wait_hi(1, BW + 100);
    $display("test break-select done");

    s = 3'h2;
    while (s == 3'h2 || s == 3'h4)
      s = 3'($urandom);
    @(posedge clk);
    image_present <= 1'h1;
    i_prog.boot(s);
    wait_hi(2, 50);
    @(posedge clk);
    #1;
    chk(format_start, 1'h0);
    x = $urandom;
    wr_reg(bml_pkg::OFS_FSSIZE, x);
    repeat (50) @(posedge clk);
    #1;
    chk({run_enable, jtag_4wire}, 2'h0);
    @(posedge clk);
    format_done <= 1'h1;
    @(posedge clk);
    format_done <= 1'h0;
    wait_hi(1, 20);
    chk(image_protect, 1'h1);
    wr_reg(bml_pkg::OFS_FSSIZE, ~x);
    rd_reg(bml_pkg::OFS_FSSIZE, d);
    chk(d, x);
    i_prog.boot(s);
    wait_hi(1, 50);
    rd_reg(bml_pkg::OFS_STATUS, d);
    chk({d[10:8], d[4:3]}, {3'h4, 2'h2});
    chk(fs_cnt, 1);
    $display("test first boot done");
    final_report();
  end
endmodule // bml_loader_test

// *** verification/bml_programmer.sv ***
// Production programmer model: straps, pin reset and serial link
module bml_programmer #(
  parameter int BIT_CYC = bml_pkg::BIT_CYCLES
) (
  // Clock
  input  wire logic clk,
  // Device pins
  input  wire logic txd,
  output logic      rxd,
  output logic      reset_n_pin,
  output logic [2:0] boot_strap_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rxd = 1'h1;
    reset_n_pin = 1'h0;
    boot_strap_pins = 3'h0;
  end

  ////////////////////////////////////////////////////////////
  // Long low pulse so the synchronised pin reset is seen
  task automatic boot(input logic [2:0] s);
    @(posedge clk);
    reset_n_pin <= 1'h0;
    boot_strap_pins <= s;
    repeat (8) @(posedge clk);
    reset_n_pin <= 1'h1;
  endtask

  task automatic set_strap(input logic [2:0] s);
    @(posedge clk);
    boot_strap_pins <= s;
  endtask

  // Only the data lines are driven, no handshake lines
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  task automatic send_break();
    @(posedge clk);
    rxd <= 1'h0;
    repeat (12 * BIT_CYC) @(posedge clk);
    rxd <= 1'h1;
  endtask

  // Gives up after 2000 cycles with ok low
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    b = 8'h00;
    while (txd !== 1'h0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n < 2000)
    begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        if (i < 8)
          b[i] = txd;
        else
          ok = (txd === 1'h1);
      end
    end
  endtask
endmodule // bml_programmer
